// file: design/alert_mon_consts.svh
// Offsets, field positions, reset values and command codes of the alert monitor.
// Assumes inclusion by bare name from the design files that need them.
`ifndef ALERT_MON_CONSTS_SVH
`define ALERT_MON_CONSTS_SVH

`define ADDR_CFG1 4'h1
`define ADDR_CFG2 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_LOW 4'h4
`define ADDR_HIGH 4'h5

`define ST_CRC_BIT 9
`define ST_SETUP_BIT 8
`define ST_B_OVER_BIT 5
`define ST_B_UNDER_BIT 4
`define ST_A_OVER_BIT 1
`define ST_A_UNDER_BIT 0

`define LOW_RST 12'h800
`define HIGH_RST 12'h7ff
`define LOW_PAD 4'h0
`define HIGH_PAD 4'hf

`define CFG1_RST 12'h000
`define CFG1_MASK 12'h3ff
`define CFG1_ALERT_EN_BIT 3
`define CFG2_ONE_WIRE_BIT 8

`define SOFT_CMD 8'h3c
`define HARD_CMD 8'hff

`endif

// file: design/alert_mon_pkg.sv
// Types shared by the alert monitor and its comparator.
// Assumes nothing of its surroundings.
package alert_mon_pkg;
  typedef logic [15:0] word_t;
  typedef logic [11:0] limit_t;
  typedef logic [3:0] reg_addr_t;
  typedef logic [3:0] flags_t;
endpackage

// file: design/limit_cmp_if.sv
// Carrier between the monitor and one channel comparator.
// Assumes both ends share one clock domain; the interface holds no state.
`timescale 1ns/1ns
`default_nettype none
interface limit_cmp_if;
  import alert_mon_pkg::*;
  word_t low_thr;
  word_t high_thr;
  word_t sample;
  logic valid;
  logic under;
  logic over;
  modport cmp (input low_thr, input high_thr, input sample, input valid,
               output under, output over);
  modport ctl (output low_thr, output high_thr, output sample, output valid,
               input under, input over);
endinterface
`default_nettype wire

// file: design/threshold_compare.sv
// One channel comparator: flags a valid sample outside the expanded limits.
// Assumes the thresholds arrive already expanded to 16 bits.
`timescale 1ns/1ns
`default_nettype none
module threshold_compare (
  limit_cmp_if.cmp port
);
  import alert_mon_pkg::*;

  // The conditions are combinational; the caller turns them into sticky flags.
  assign port.under = port.valid && (port.sample < port.low_thr);
  assign port.over = port.valid && (port.sample > port.high_thr);
endmodule
`default_nettype wire

// file: design/adc_result_alert_monitor.sv
// Alert monitor register bank: thresholds, sticky status flags, reset commands.
// Assumes the serial front end decodes frames and checks CRC on the same clock,
// presenting one-cycle read and write strobes with the frame's address and data.
`timescale 1ns/1ns
`default_nettype none
`include "alert_mon_consts.svh"

// Functional notes
// - CRC-rejected write sets status bit 9.
// - CRC and alert flags sticky, status read clears.
// - Startup load failure sets status bit 8.
// - Status read leaves load-error flag alone.
// - Only hard reset clears load error, restarts setup.
// - Channel B above high threshold sets bit 5.
// - Channel B below low threshold sets bit 4.
// - Channel A above high threshold sets bit 1.
// - Channel A below low threshold sets bit 0.
// - Low threshold is limit over four zero bits.
// - High threshold is limit over four one bits.
// - Low alert when result below low threshold.
// - High alert when result above high threshold.
// - Low limit register resets to 0x0800.
// - High limit register resets to 0x07FF.
// - Readback carries register address in bits 15:12.
// - Second pin alerts only if enabled and one-wire.
module adc_result_alert_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic wr_crc_ok_i,
  input wire logic rd_i,
  input wire alert_mon_pkg::reg_addr_t addr_i,
  input wire alert_mon_pkg::limit_t wdata_i,
  input wire logic conv_valid_i,
  input wire alert_mon_pkg::word_t conv_a_i,
  input wire alert_mon_pkg::word_t conv_b_i,
  input wire logic setup_fail_i,
  input wire logic chan_b_data_i,
  output logic [15:0] rdata_o,
  output logic rdata_valid_o,
  output logic second_out_pin_o,
  output logic setup_restart_o
);
  import alert_mon_pkg::*;

  limit_t low_r;
  limit_t low_nxt;
  limit_t high_r;
  limit_t high_nxt;
  limit_t cfg1_r;
  limit_t cfg1_nxt;
  logic one_wire_r;
  logic one_wire_nxt;
  flags_t flags_r;
  flags_t flags_nxt;
  logic crc_fault_r;
  logic crc_fault_nxt;
  logic setup_fault_r;
  logic setup_fault_nxt;
  word_t rdata_r;
  word_t rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic pin_r;
  logic pin_nxt;
  logic restart_r;
  logic restart_nxt;
  flags_t events;
  word_t samples [2];
  logic wr_ok;
  logic wr_bad;
  logic soft_cmd;
  logic hard_cmd;
  logic status_clear;

  // Address match, used by both the write and the read decode.
  function automatic logic reg_hit(input reg_addr_t a, input reg_addr_t target);
    reg_hit = (a == target);
  endfunction

  // Threshold expansion keeps 12 programmable bits and pads the low nibble.
  function automatic word_t expand_low(input limit_t lim);
    expand_low = {lim, `LOW_PAD};
  endfunction

  function automatic word_t expand_high(input limit_t lim);
    expand_high = {lim, `HIGH_PAD};
  endfunction

  // Status word as the host sees it; the address nibble cannot be written.
  function automatic word_t status_word(input logic crc, input logic setup,
                                        input flags_t fl);
    word_t w;
    w = 16'h0000;
    w[15:12] = `ADDR_STATUS;
    w[`ST_CRC_BIT] = crc;
    w[`ST_SETUP_BIT] = setup;
    w[`ST_B_OVER_BIT] = fl[3];
    w[`ST_B_UNDER_BIT] = fl[2];
    w[`ST_A_OVER_BIT] = fl[1];
    w[`ST_A_UNDER_BIT] = fl[0];
    status_word = w;
  endfunction

  assign samples[0] = conv_a_i;
  assign samples[1] = conv_b_i;

  // One comparator per channel; both see the same pair of limits.
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_chan
      limit_cmp_if cmp_bus ();
      assign cmp_bus.low_thr = expand_low(low_r);
      assign cmp_bus.high_thr = expand_high(high_r);
      assign cmp_bus.sample = samples[g];
      assign cmp_bus.valid = conv_valid_i;
      assign events[2*g] = cmp_bus.under;
      assign events[2*g+1] = cmp_bus.over;
      threshold_compare u_cmp (
        .port(cmp_bus.cmp)
      );
    end
  endgenerate

  // Command decode: a write that fails its CRC never reaches a register.
  always_comb
  begin
    wr_ok = wr_i && wr_crc_ok_i;
    wr_bad = wr_i && !wr_crc_ok_i;
    soft_cmd = wr_ok && reg_hit(addr_i, `ADDR_CFG2) && (wdata_i[7:0] == `SOFT_CMD);
    hard_cmd = wr_ok && reg_hit(addr_i, `ADDR_CFG2) && (wdata_i[7:0] == `HARD_CMD);
    status_clear = (rd_i && reg_hit(addr_i, `ADDR_STATUS)) || soft_cmd || hard_cmd;
  end

  // Register writes, then a hard reset overrides every stored value.
  always_comb
  begin
    low_nxt = low_r;
    high_nxt = high_r;
    cfg1_nxt = cfg1_r;
    one_wire_nxt = one_wire_r;
    if (wr_ok)
    begin
      if (reg_hit(addr_i, `ADDR_LOW))
      begin
        low_nxt = wdata_i;
      end
      if (reg_hit(addr_i, `ADDR_HIGH))
      begin
        high_nxt = wdata_i;
      end
      if (reg_hit(addr_i, `ADDR_CFG1))
      begin
        cfg1_nxt = wdata_i & `CFG1_MASK;
      end
      if (reg_hit(addr_i, `ADDR_CFG2))
      begin
        one_wire_nxt = wdata_i[`CFG2_ONE_WIRE_BIT];
      end
    end
    if (hard_cmd)
    begin
      low_nxt = `LOW_RST;
      high_nxt = `HIGH_RST;
      cfg1_nxt = `CFG1_RST;
      one_wire_nxt = 1'b0;
    end
  end

  // Sticky flags: an alert or CRC set in the cycle of a clear wins, so no such event is lost; a hard reset beats a load failure.
  always_comb
  begin
    flags_nxt = (flags_r & ~{4{status_clear}}) | events;
    crc_fault_nxt = (crc_fault_r && !status_clear) || wr_bad;
    // Reads and soft resets leave the load error alone.
    if (hard_cmd)
    begin
      setup_fault_nxt = 1'b0;
    end
    else
    begin
      setup_fault_nxt = setup_fault_r || setup_fail_i;
    end
    restart_nxt = hard_cmd;
  end

  // Readback uses the value before this cycle's clear, so a read reports the event.
  always_comb
  begin
    rdata_nxt = rdata_r;
    rvalid_nxt = rd_i;
    if (rd_i)
    begin
      if (reg_hit(addr_i, `ADDR_STATUS))
      begin
        rdata_nxt = status_word(crc_fault_r, setup_fault_r, flags_r);
      end
      else if (reg_hit(addr_i, `ADDR_LOW))
      begin
        rdata_nxt = {addr_i, low_r};
      end
      else if (reg_hit(addr_i, `ADDR_HIGH))
      begin
        rdata_nxt = {addr_i, high_r};
      end
      else if (reg_hit(addr_i, `ADDR_CFG1))
      begin
        rdata_nxt = {addr_i, cfg1_r};
      end
      else if (reg_hit(addr_i, `ADDR_CFG2))
      begin
        rdata_nxt = {addr_i, 3'h0, one_wire_r, 8'h00};
      end
      else
      begin
        rdata_nxt = {addr_i, 12'h000};
      end
    end
  end

  // The pin takes the alert role only in one-wire mode with alerts enabled; otherwise lane B data passes.
  always_comb
  begin
    if (cfg1_r[`CFG1_ALERT_EN_BIT] && one_wire_r)
    begin
      pin_nxt = |flags_nxt;
    end
    else
    begin
      pin_nxt = chan_b_data_i;
    end
  end

  // Register bank state; reset values match the hard-reset defaults.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      low_r <= `LOW_RST;
      high_r <= `HIGH_RST;
      cfg1_r <= `CFG1_RST;
      one_wire_r <= 1'b0;
    end
    else
    begin
      low_r <= low_nxt;
      high_r <= high_nxt;
      cfg1_r <= cfg1_nxt;
      one_wire_r <= one_wire_nxt;
    end
  end

  // Status flags and the setup restart pulse.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      flags_r <= 4'h0;
      crc_fault_r <= 1'b0;
      setup_fault_r <= 1'b0;
      restart_r <= 1'b0;
    end
    else
    begin
      flags_r <= flags_nxt;
      crc_fault_r <= crc_fault_nxt;
      setup_fault_r <= setup_fault_nxt;
      restart_r <= restart_nxt;
    end
  end

  // Readback word and its one-cycle valid pulse.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Second output pin; held low in reset so no false alert is seen by the host.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_r <= 1'b0;
    end
    else
    begin
      pin_r <= pin_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign rdata_valid_o = rvalid_r;
  assign second_out_pin_o = pin_r;
  assign setup_restart_o = restart_r;
endmodule
`default_nettype wire

// file: bench/alert_mon_sva.sv
// Checker on the alert monitor's ports.
// Assumes binding to the top module.
`timescale 1ns/1ns
`default_nettype none
module alert_mon_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic wr_crc_ok_i,
  input wire logic rd_i,
  input wire alert_mon_pkg::reg_addr_t addr_i,
  input wire alert_mon_pkg::limit_t wdata_i,
  input wire logic conv_valid_i,
  input wire logic setup_fail_i,
  input wire logic [15:0] rdata_o,
  input wire logic rdata_valid_o,
  input wire logic setup_restart_o
);
  import alert_mon_pkg::*;
  logic st;
  logic hard;
  logic bad;
  // Decoded strobes shared by the properties.
  assign st = rd_i && addr_i == 4'h3;
  assign hard = wr_i && wr_crc_ok_i && addr_i == 4'h2 && wdata_i[7:0] == 8'hff;
  assign bad = wr_i && !wr_crc_ok_i;
  // Any accepted write that clears the status flags.
  logic clr;
  assign clr = hard || (wr_i && wr_crc_ok_i && addr_i == 4'h2 && wdata_i[7:0] == 8'h3c);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_valid: assert property (rd_i |=> rdata_valid_o)
    else $error("no read answer");
  a_valid_once: assert property (!rd_i |=> !rdata_valid_o)
    else $error("stray read answer");
  a_addr_field: assert property (rd_i |=> rdata_o[15:12] == $past(addr_i))
    else $error("bad address field");
  a_crc_flag: assert property (bad ##1 (!st && !clr) ##1 st |=> rdata_o[9])
    else $error("crc flag missing");
  a_setup_flag: assert property ((setup_fail_i && !hard) ##1 !hard ##1 st |=> rdata_o[8])
    else $error("load flag missing");
  a_setup_kept: assert property ((st && !hard) ##1 (rdata_o[8] && !hard) ##1 st
    |=> rdata_o[8]) else $error("load flag lost");
  a_read_clears: assert property ((st && !conv_valid_i && !bad) ##1
    (!conv_valid_i && !bad) ##1 st |=> (rdata_o & 16'h0233) == 16'h0000)
    else $error("flags not cleared");
  a_hard_pulse: assert property (hard |=> setup_restart_o ##1
    (setup_restart_o == $past(hard))) else $error("bad restart pulse");
  a_restart_cause: assert property (!hard |=> !setup_restart_o)
    else $error("stray restart");
endmodule
bind adc_result_alert_monitor alert_mon_sva u_alert_mon_sva (.clk_i, .rst_n_i, .wr_i,
  .wr_crc_ok_i, .rd_i, .addr_i, .wdata_i, .conv_valid_i, .setup_fail_i, .rdata_o,
  .rdata_valid_o, .setup_restart_o);
`default_nettype wire

// file: bench/host_model.sv
// Host controller model issuing register frames.
// Assumes strobes change at the falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output var logic wr_o = 1'b0,
  output var logic ok_o = 1'b1,
  output var logic rd_o = 1'b0,
  output var alert_mon_pkg::reg_addr_t addr_o = 4'h0,
  output var alert_mon_pkg::limit_t wdata_o = 12'h000
);
  import alert_mon_pkg::*;
  // One frame per call; address and data are inverted afterwards so stale values never look live.
  task automatic put(input reg_addr_t a, input limit_t d, input logic ok);
    @(negedge clk_i);
    wr_o = 1'b1;
    ok_o = ok;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // The answer is registered, so it is settled by the next falling edge.
  task automatic get(input reg_addr_t a, output word_t q);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// file: bench/test_adc_result_alert_monitor.sv
// Self-checking bench for the alert monitor.
// Assumes the host model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module test_adc_result_alert_monitor;
  import alert_mon_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cv = 1'b0;
  word_t ca = 16'h0000;
  word_t cb = 16'h0000;
  logic sf = 1'b0;
  logic bd = 1'b0;
  logic wr, ok, rd, rv, pin, rs;
  reg_addr_t addr;
  limit_t wd;
  logic [15:0] rdata;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  adc_result_alert_monitor u_adc_result_alert_monitor (.clk_i, .rst_n_i, .wr_i(wr),
    .wr_crc_ok_i(ok), .rd_i(rd), .addr_i(addr), .wdata_i(wd), .conv_valid_i(cv),
    .conv_a_i(ca), .conv_b_i(cb), .setup_fail_i(sf), .chan_b_data_i(bd), .rdata_o(rdata),
    .rdata_valid_o(rv), .second_out_pin_o(pin), .setup_restart_o(rs));
  host_model u_host_model (.clk_i, .rdata_i(rdata), .wr_o(wr), .ok_o(ok), .rd_o(rd),
    .addr_o(addr), .wdata_o(wd));
  // Free-running 20 MHz clock.
  always #25 clk_i = ~clk_i;
  task automatic tally_and_finish();
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input word_t e, input word_t g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input reg_addr_t a, input word_t e);
    word_t q;
    u_host_model.get(a, q);
    chk("readback", e, q);
    chk("read valid", 16'h0001, {15'h0, rv});
  endtask
  task automatic conv(input word_t a, input word_t b);
    @(negedge clk_i);
    cv = 1'b1;
    ca = a;
    cb = b;
    @(negedge clk_i);
    cv = 1'b0;
  endtask
  task automatic t_defaults();
    rchk(4'h3, 16'h3000);
    rchk(4'h4, 16'h4800);
    rchk(4'h5, 16'h57ff);
    rchk(4'h0, 16'h0000);
  endtask
  // Values sit on the padded limits or one code beyond them.
  task automatic t_alerts();
    u_host_model.put(4'h4, 12'h100, 1'b1);
    u_host_model.put(4'h5, 12'hf00, 1'b1);
    conv(16'h0fff, 16'hf010);
    rchk(4'h3, 16'h3021);
    rchk(4'h3, 16'h3000);
    conv(16'h1000, 16'hf00f);
    conv(16'hf010, 16'h0fff);
    rchk(4'h3, 16'h3012);
  endtask
  task automatic t_crc();
    u_host_model.put(4'h4, 12'h123, 1'b0);
    rchk(4'h3, 16'h3200);
    rchk(4'h4, 16'h4100);
  endtask
  task automatic t_setup();
    @(negedge clk_i);
    sf = 1'b1;
    @(negedge clk_i);
    sf = 1'b0;
    rchk(4'h3, 16'h3100);
    rchk(4'h3, 16'h3100);
    conv(16'h0000, 16'h0000);
    u_host_model.put(4'h2, 12'h03c, 1'b1);
    chk("restart", 16'h0000, {15'h0, rs});
    rchk(4'h3, 16'h3100);
    rchk(4'h4, 16'h4100);
    u_host_model.put(4'h2, 12'h0ff, 1'b1);
    chk("restart", 16'h0001, {15'h0, rs});
    rchk(4'h3, 16'h3000);
    rchk(4'h4, 16'h4800);
  endtask
  task automatic t_pin();
    u_host_model.put(4'h1, 12'h008, 1'b1);
    u_host_model.put(4'h2, 12'h100, 1'b1);
    conv(16'h0000, 16'h8000);
    chk("pin", 16'h0001, {15'h0, pin});
    rchk(4'h3, 16'h3021);
    @(negedge clk_i);
    chk("pin", 16'h0000, {15'h0, pin});
    u_host_model.put(4'h2, 12'h000, 1'b1);
    bd = 1'b1;
    @(negedge clk_i);
    chk("pin", 16'h0001, {15'h0, pin});
  endtask
  // Main sequence after six reset cycles.
  initial
  begin
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_defaults();
    t_alerts();
    t_crc();
    t_setup();
    t_pin();
    tally_and_finish();
  end
  // A hang is cut short well beyond the expected seventy or so cycles.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      tally_and_finish();
    end
  end
endmodule
`default_nettype wire
